// [inc/ssr_map.vh]
`ifndef SSR_MAP_VH
`define SSR_MAP_VH

// ----------------------------------------
// Register sets
// ----------------------------------------
`define SSR_NSETS 5
`define SSR_SET_TRG 3'h0
`define SSR_SET_ULF 3'h1
`define SSR_SET_QTOP 3'h2
`define SSR_SET_CAL 3'h3
`define SSR_SET_PWR 3'h4

// ----------------------------------------
// Address layout: set in [7:5], field in [4:2]
// ----------------------------------------
`define SSR_SET_MSB 7
`define SSR_SET_LSB 5
`define SSR_FLD_MSB 4
`define SSR_FLD_LSB 2
`define SSR_FLD_COND 3'h0
`define SSR_FLD_EVENT 3'h1
`define SSR_FLD_PTR 3'h2
`define SSR_FLD_NTR 3'h3
`define SSR_FLD_ENABLE 3'h4
`define SSR_CTRL_ADDR 8'ha0
`define SSR_CTRL_PRESET 0

// ----------------------------------------
// Implemented bits of each set
// ----------------------------------------
`define SSR_MASK_TRG 16'h0006
`define SSR_MASK_ULF 16'h0078
`define SSR_MASK_QTOP 16'h0308
`define SSR_MASK_CAL2 16'h0006
`define SSR_MASK_CAL4 16'h001e
`define SSR_MASK_PWR2 16'h01fe
`define SSR_MASK_PWR4 16'h07fe

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SSR_TRG_A 1
`define SSR_ULF_LSB 3
`define SSR_QTOP_PWR 3
`define SSR_QTOP_CAL 8
`define SSR_QTOP_POST 9
`define SSR_CAL_LSB 1
`define SSR_PWR_A 1
`define SSR_PWR_B 2
`define SSR_PWR_UW 3
`define SSR_PWR_LW 4
`define SSR_PWR_ZA 5
`define SSR_PWR_ZB 6
`define SSR_PWR_UWLM 7
`define SSR_PWR_LWLM 8
`define SSR_PWR_C 9
`define SSR_PWR_D 10

// ----------------------------------------
// Preset and reset values
// ----------------------------------------
`define SSR_ONES 16'hffff
`define SSR_ZERO 16'h0000
`define SSR_READ_MASK 16'h7fff

`endif

// [src/ssr_top.v]
// How it works
// - Trigger set: channel A bit1, B bit2
// - Upper-limit-fail set uses bits three to six
// - Failed upper or window check sets bit
// - Clear only on enabled passing measurement
// - Preset questionable top set: enable zero, PTR ones
// - Preset others: enable ones, PTR ones, NTR zero
// - Questionable bit3 is power set summary
// - Questionable bit8 is calibration set summary
// - Questionable bit9 follows self-test failure
// - Calibration bits one to four, channels A-D
// - Zeroing or calibration error sets bit
// - Clean zeroing or calibration completion clears
// - Power bits: channels, windows, needs-zeroing
// - Power bits seven, eight limit errors; nine, ten extra channels
// - Overload, general or A, sets bit1
// - Channel B overload sets bit2
// - Stale data or upper log error: bit3
// - Stale data or lower log error: bit4
// - Needs-zeroing levels set bits five, six
// - Power bit clears on cause-free measurement
// - Reading an event register clears it
// - Event latches on filtered condition edge
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "ssr_map.vh"

module ssr_top #(
  parameter EXTRA_CH = 0
) (
  input wire CORE_CLK,
  input wire RESET_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire TRIG_A,
  input wire TRIG_B,
  input wire MEAS_DONE,
  input wire [3:0] ULF_FAIL,
  input wire [3:0] ULF_CHECK_EN,
  input wire [3:0] ULF_PASS,
  input wire CAL_ERR_ALL,
  input wire [3:0] CAL_ERR,
  input wire [3:0] CAL_OK,
  input wire OVL_GEN,
  input wire OVL_A,
  input wire OVL_B,
  input wire [1:0] OVL_CD,
  input wire DATA_STALE,
  input wire LOG_ERR_UW,
  input wire LOG_ERR_LW,
  input wire [1:0] LM_PWR_ERR,
  input wire NEEDS_ZERO_A,
  input wire NEEDS_ZERO_B,
  input wire SELFTEST_DONE,
  input wire SELFTEST_FAIL,
  output reg TRG_SUMMARY,
  output reg ULF_SUMMARY,
  output reg QUES_SUMMARY
);

  // ----------------------------------------
  // Set masks
  // ----------------------------------------
  localparam [15:0] CAL_MASK = (EXTRA_CH != 0) ? `SSR_MASK_CAL4 : `SSR_MASK_CAL2;
  localparam [15:0] PWR_MASK = (EXTRA_CH != 0) ? `SSR_MASK_PWR4 : `SSR_MASK_PWR2;

  function [15:0] set_mask;
    input [2:0] s;
    begin
      if (s == `SSR_SET_TRG) begin
        set_mask = `SSR_MASK_TRG;
      end else if (s == `SSR_SET_ULF) begin
        set_mask = `SSR_MASK_ULF;
      end else if (s == `SSR_SET_QTOP) begin
        set_mask = `SSR_MASK_QTOP;
      end else if (s == `SSR_SET_CAL) begin
        set_mask = CAL_MASK;
      end else if (s == `SSR_SET_PWR) begin
        set_mask = PWR_MASK;
      end else begin
        set_mask = `SSR_ZERO;
      end
    end
  endfunction

  // Top set presets enable to zero, the others to ones
  function [15:0] preset_enable;
    input [2:0] s;
    begin
      if (s == `SSR_SET_QTOP) begin
        preset_enable = `SSR_ZERO;
      end else begin
        preset_enable = `SSR_ONES;
      end
    end
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire [2:0] addr_set = PADDR[`SSR_SET_MSB:`SSR_SET_LSB];
  wire [2:0] addr_fld = PADDR[`SSR_FLD_MSB:`SSR_FLD_LSB];
  wire addr_ctrl = (PADDR == `SSR_CTRL_ADDR);
  wire addr_set_ok = (addr_set < 3'h`SSR_NSETS) && (addr_fld <= `SSR_FLD_ENABLE) && (PADDR[1:0] == 2'h0);
  wire access = PSEL & PENABLE & ~PREADY;
  wire done = PSEL & PENABLE & PREADY;
  wire wr_done = done & PWRITE & ~PSLVERR;
  wire rd_done = done & ~PWRITE & ~PSLVERR;
  wire preset = wr_done & addr_ctrl & PWDATA[`SSR_CTRL_PRESET];

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg [15:0] cond_q [0:`SSR_NSETS-1];
  reg [15:0] prev_q [0:`SSR_NSETS-1];
  reg [15:0] event_q [0:`SSR_NSETS-1];
  reg [15:0] ptr_q [0:`SSR_NSETS-1];
  reg [15:0] ntr_q [0:`SSR_NSETS-1];
  reg [15:0] enable_q [0:`SSR_NSETS-1];
  wire [15:0] cond_d [0:`SSR_NSETS-1];
  wire [`SSR_NSETS-1:0] summary;

  // ----------------------------------------
  // Condition sources
  // ----------------------------------------
  wire [15:0] trg_level = ({15'h0000, TRIG_A} << `SSR_TRG_A) | ({15'h0000, TRIG_B} << (`SSR_TRG_A + 1));
  assign cond_d[`SSR_SET_TRG] = trg_level & `SSR_MASK_TRG;

  wire [15:0] ulf_set = {12'h000, ULF_FAIL} << `SSR_ULF_LSB;
  wire [15:0] ulf_clr = {12'h000, ULF_PASS & ULF_CHECK_EN & {4{MEAS_DONE}}} << `SSR_ULF_LSB;
  // A fail reported with the completing pass keeps the bit
  assign cond_d[`SSR_SET_ULF] = ((cond_q[`SSR_SET_ULF] & ~ulf_clr) | ulf_set) & `SSR_MASK_ULF;

  reg post_fail_q;
  wire [15:0] qtop_level = ({15'h0000, summary[`SSR_SET_PWR]} << `SSR_QTOP_PWR) |
    ({15'h0000, summary[`SSR_SET_CAL]} << `SSR_QTOP_CAL) | ({15'h0000, post_fail_q} << `SSR_QTOP_POST);
  assign cond_d[`SSR_SET_QTOP] = qtop_level & `SSR_MASK_QTOP;

  // Overall calibration error marks every present channel
  wire [15:0] cal_set = {12'h000, CAL_ERR | {4{CAL_ERR_ALL}}} << `SSR_CAL_LSB;
  wire [15:0] cal_clr = {12'h000, CAL_OK} << `SSR_CAL_LSB;
  assign cond_d[`SSR_SET_CAL] = ((cond_q[`SSR_SET_CAL] & ~cal_clr) | cal_set) & CAL_MASK;

  reg [15:0] pwr_set;
  always @* begin
    pwr_set = `SSR_ZERO;
    pwr_set[`SSR_PWR_A] = OVL_GEN | OVL_A;
    pwr_set[`SSR_PWR_B] = OVL_B;
    pwr_set[`SSR_PWR_UW] = DATA_STALE | LOG_ERR_UW;
    pwr_set[`SSR_PWR_LW] = DATA_STALE | LOG_ERR_LW;
    pwr_set[`SSR_PWR_ZA] = NEEDS_ZERO_A;
    pwr_set[`SSR_PWR_ZB] = NEEDS_ZERO_B;
    pwr_set[`SSR_PWR_UWLM] = LM_PWR_ERR[0];
    pwr_set[`SSR_PWR_LWLM] = LM_PWR_ERR[1];
    pwr_set[`SSR_PWR_C] = OVL_CD[0];
    pwr_set[`SSR_PWR_D] = OVL_CD[1];
  end
  // Measurement end keeps only bits whose cause is still present
  wire [15:0] pwr_keep = MEAS_DONE ? `SSR_ZERO : cond_q[`SSR_SET_PWR];
  assign cond_d[`SSR_SET_PWR] = (pwr_keep | pwr_set) & PWR_MASK;

  // ----------------------------------------
  // Self-test result
  // ----------------------------------------
  always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      post_fail_q <= 1'b0;
    end else if (SELFTEST_DONE) begin
      post_fail_q <= SELFTEST_FAIL;
    end
  end

  // ----------------------------------------
  // Per-set condition, event and filters
  // ----------------------------------------
  reg [15:0] rd_clr_q;
  reg [2:0] rd_set_q;
  reg rd_event_q;

  genvar s;
  generate
    for (s = 0; s < `SSR_NSETS; s = s + 1) begin : g_set
      localparam [15:0] MASK = set_mask(s);
      wire sel = (addr_set == s) & addr_set_ok;
      wire [15:0] rise = cond_q[s] & ~prev_q[s] & ptr_q[s];
      wire [15:0] fall = ~cond_q[s] & prev_q[s] & ntr_q[s];
      wire [15:0] ev_clr = (rd_event_q && rd_set_q == s && rd_done) ? rd_clr_q : `SSR_ZERO;
      assign summary[s] = |(event_q[s] & enable_q[s]);
      always @(posedge CORE_CLK) begin
        if (!RESET_N) begin
          cond_q[s] <= `SSR_ZERO;
          prev_q[s] <= `SSR_ZERO;
          event_q[s] <= `SSR_ZERO;
          ptr_q[s] <= `SSR_ONES & MASK;
          ntr_q[s] <= `SSR_ZERO;
          enable_q[s] <= preset_enable(s) & MASK;
        end else begin
          cond_q[s] <= cond_d[s];
          prev_q[s] <= cond_q[s];
          // New edges win over the read clear
          event_q[s] <= ((event_q[s] & ~ev_clr) | rise | fall) & MASK;
          if (preset) begin
            ptr_q[s] <= `SSR_ONES & MASK;
            ntr_q[s] <= `SSR_ZERO;
            enable_q[s] <= preset_enable(s) & MASK;
          end else if (wr_done && sel) begin
            if (addr_fld == `SSR_FLD_PTR) begin
              ptr_q[s] <= PWDATA[15:0] & MASK;
            end else if (addr_fld == `SSR_FLD_NTR) begin
              ntr_q[s] <= PWDATA[15:0] & MASK;
            end else if (addr_fld == `SSR_FLD_ENABLE) begin
              enable_q[s] <= PWDATA[15:0] & MASK;
            end
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  reg [15:0] rd_val;
  always @* begin
    rd_val = `SSR_ZERO;
    // Sets past the last one would index outside the arrays
    if (!addr_set_ok) begin
      rd_val = `SSR_ZERO;
    end else if (addr_fld == `SSR_FLD_COND) begin
      rd_val = cond_q[addr_set];
    end else if (addr_fld == `SSR_FLD_EVENT) begin
      rd_val = event_q[addr_set];
    end else if (addr_fld == `SSR_FLD_PTR) begin
      rd_val = ptr_q[addr_set];
    end else if (addr_fld == `SSR_FLD_NTR) begin
      rd_val = ntr_q[addr_set];
    end else if (addr_fld == `SSR_FLD_ENABLE) begin
      rd_val = enable_q[addr_set];
    end
  end

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      rd_clr_q <= `SSR_ZERO;
      rd_set_q <= 3'h0;
      rd_event_q <= 1'b0;
    end else begin
      PREADY <= access;
      if (access) begin
        // Control word reads as zero; unmapped addresses error
        PSLVERR <= ~(addr_set_ok | addr_ctrl);
        // Only the returned bits are cleared, later events survive
        PRDATA <= (addr_set_ok && !PWRITE) ? {16'h0000, rd_val & `SSR_READ_MASK} : 32'h0000_0000;
        rd_clr_q <= rd_val;
        rd_set_q <= addr_set;
        rd_event_q <= addr_set_ok & (addr_fld == `SSR_FLD_EVENT);
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Summary outputs
  // ----------------------------------------
  always @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      TRG_SUMMARY <= 1'b0;
      ULF_SUMMARY <= 1'b0;
      QUES_SUMMARY <= 1'b0;
    end else begin
      TRG_SUMMARY <= summary[`SSR_SET_TRG];
      ULF_SUMMARY <= summary[`SSR_SET_ULF];
      QUES_SUMMARY <= summary[`SSR_SET_QTOP];
    end
  end

endmodule // ssr_top

`default_nettype wire

// [sim/ssr_properties.sv]
`timescale 1ns/1ns
`default_nettype none
// ----
// Port checks
// ----
module ssr_properties (
  input wire CORE_CLK,
  input wire RESET_N,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire TRG_SUMMARY,
  input wire ULF_SUMMARY,
  input wire QUES_SUMMARY
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // Writes return zero read data, so only reads are checked
  property p_bits(logic [2:0] s, logic [31:0] m);
    PREADY && !PWRITE && PADDR[7:5] == s |-> (PRDATA & ~m) == 32'h0;
  endproperty
  AST_READY_NEXT: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("ready late");
  AST_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready too long");
  AST_READY_CAUSE: assert property ($rose(PREADY) |-> $past(PSEL && PENABLE))
    else $error("ready without access");
  AST_RESET_QUIET: assert property (disable iff (1'b0) !RESET_N |=> !PREADY && !PSLVERR && PRDATA == 32'h0
    && !TRG_SUMMARY && !ULF_SUMMARY && !QUES_SUMMARY) else $error("outputs busy in reset");
  AST_BIT15: assert property (PREADY |-> PRDATA[31:15] == 17'h0)
    else $error("high bits set");
  AST_TRG_BITS: assert property (p_bits(3'h0, 32'h6))
    else $error("trigger bits");
  AST_ULF_BITS: assert property (p_bits(3'h1, 32'h78))
    else $error("limit bits");
  AST_QTOP_BITS: assert property (p_bits(3'h2, 32'h308))
    else $error("top bits");
  AST_PWR_BITS: assert property (p_bits(3'h4, 32'h1fe))
    else $error("power bits");
  AST_CAL_BITS: assert property (p_bits(3'h3, 32'h1e))
    else $error("calibration bits");
  AST_UNMAPPED: assert property (PREADY && PADDR > 8'ha0 |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped accepted");
  AST_ERR_ALONE: assert property (PSLVERR |-> PREADY)
    else $error("stray error");
  cover property (PREADY && PSLVERR);
  cover property ($rose(TRG_SUMMARY));
  cover property ($rose(ULF_SUMMARY));
  cover property ($rose(QUES_SUMMARY));
endmodule // ssr_properties
bind ssr_top ssr_properties chk_u (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .TRG_SUMMARY(TRG_SUMMARY), .ULF_SUMMARY(ULF_SUMMARY), .QUES_SUMMARY(QUES_SUMMARY));
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic CORE_CLK = 0, RESET_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, TRIG_A = 0, TRIG_B = 0;
  logic MEAS_DONE = 0, CAL_ERR_ALL = 0, SELFTEST_DONE = 0, SELFTEST_FAIL = 0, e;
  logic [7:0] PADDR = 0;
  logic [31:0] PWDATA = 0, r;
  logic [3:0] ULF_FAIL = 0, ULF_CHECK_EN = 0, ULF_PASS = 0, CAL_ERR = 0, CAL_OK = 0;
  logic [11:0] pc = 0;
  wire [31:0] PRDATA;
  wire PREADY, PSLVERR, TRG_SUMMARY, ULF_SUMMARY, QUES_SUMMARY;
  int fails = 0, comparisons = 0, cyc = 0, i;
  logic [31:0] m [5] = '{32'h6, 32'h78, 32'h308, 32'h6, 32'h1fe};
  // Extra channels absent, so their causes light nothing
  logic [31:0] pe [12] = '{2, 2, 4, 'h18, 8, 'h10, 'h20, 'h40, 'h80, 'h100, 0, 0};
  ssr_top dut_u (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TRIG_A(TRIG_A),
    .TRIG_B(TRIG_B), .MEAS_DONE(MEAS_DONE), .ULF_FAIL(ULF_FAIL), .ULF_CHECK_EN(ULF_CHECK_EN),
    .ULF_PASS(ULF_PASS), .CAL_ERR_ALL(CAL_ERR_ALL), .CAL_ERR(CAL_ERR), .CAL_OK(CAL_OK), .OVL_GEN(pc[0]),
    .OVL_A(pc[1]), .OVL_B(pc[2]), .DATA_STALE(pc[3]), .LOG_ERR_UW(pc[4]), .LOG_ERR_LW(pc[5]),
    .NEEDS_ZERO_A(pc[6]), .NEEDS_ZERO_B(pc[7]), .LM_PWR_ERR(pc[9:8]), .OVL_CD(pc[11:10]),
    .SELFTEST_DONE(SELFTEST_DONE), .SELFTEST_FAIL(SELFTEST_FAIL), .TRG_SUMMARY(TRG_SUMMARY),
    .ULF_SUMMARY(ULF_SUMMARY), .QUES_SUMMARY(QUES_SUMMARY));
  always #2 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 8000) begin
      fails++;
      give_verdict;
    end
  end
  task give_verdict;
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task check(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, s, x);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic err);
    @(posedge CORE_CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CORE_CLK);
    PENABLE <= 1;
    // Only the bench timeout ends a stalled wait
    do begin
      @(posedge CORE_CLK);
    end while (PREADY !== 1'b1);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, r, e);
    check(r, x);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask
  // Measure pulse; the wait covers cause-to-condition latency
  task measure;
    MEAS_DONE <= 1;
    tick(1);
    MEAS_DONE <= 0;
    tick(3);
  endtask
  task filters;
    for (i = 0; i < 5; i++) begin
      rd({i[2:0], 5'h08}, m[i]);
      rd({i[2:0], 5'h0c}, 32'h0);
      rd({i[2:0], 5'h10}, i == 2 ? 32'h0 : m[i]);
    end
  endtask
  task scen_trigger;
    TRIG_A <= 1;
    tick(6);
    check(TRG_SUMMARY, 1);
    rd(8'h00, 32'h2);
    rd(8'h04, 32'h2);
    rd(8'h04, 32'h0);
    wr(8'h10, 32'h0);
    wr(8'h0c, 32'hffff);
    TRIG_B <= 1;
    tick(6);
    check(TRG_SUMMARY, 0);
    rd(8'h00, 32'h6);
    TRIG_A <= 0;
    tick(6);
    rd(8'h04, 32'h6);
  endtask
  task scen_preset;
    for (i = 0; i < 5; i++) begin
      wr({i[2:0], 5'h08}, 32'h0);
      wr({i[2:0], 5'h10}, 32'hffff);
    end
    rd(8'h0c, 32'h6);
    rd(8'h50, 32'h308);
    wr(8'ha0, 32'h1);
    filters;
    rd(8'h00, 32'h4);
    wr(8'h00, 32'hffff);
    rd(8'h00, 32'h4);
    apb(1'b0, 8'hfc, 32'h0, r, e);
    check(e, 1);
    check(r, 0);
  endtask
  task scen_ulf;
    ULF_FAIL <= 4'h2;
    tick(1);
    ULF_FAIL <= 4'h0;
    tick(5);
    check(ULF_SUMMARY, 1);
    rd(8'h20, 32'h10);
    ULF_PASS <= 4'h2;
    measure;
    rd(8'h20, 32'h10);
    ULF_CHECK_EN <= 4'h2;
    ULF_PASS <= 4'h0;
    measure;
    rd(8'h20, 32'h10);
    ULF_PASS <= 4'h2;
    measure;
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h10);
  endtask
  task scen_power;
    for (i = 0; i < 12; i++) begin
      pc <= 12'h1 << i;
      tick(6);
      rd(8'h80, pe[i]);
      apb(1'b0, 8'h40, 32'h0, r, e);
      check(r & 32'h8, {28'h0, pe[i] != 0, 3'h0});
      rd(8'h84, pe[i]);
      pc <= 0;
      tick(3);
      rd(8'h80, pe[i]);
      measure;
      rd(8'h80, 32'h0);
    end
  endtask
  task scen_cal;
    CAL_ERR <= 4'h2;
    tick(1);
    CAL_ERR <= 0;
    tick(6);
    rd(8'h60, 32'h4);
    rd(8'h40, 32'h100);
    check(QUES_SUMMARY, 0);
    wr(8'h50, 32'h100);
    tick(3);
    check(QUES_SUMMARY, 1);
    rd(8'h44, 32'h108);
    tick(2);
    check(QUES_SUMMARY, 0);
    CAL_OK <= 4'h2;
    tick(4);
    CAL_OK <= 0;
    rd(8'h60, 32'h0);
    CAL_ERR_ALL <= 1;
    tick(4);
    CAL_ERR_ALL <= 0;
    rd(8'h60, 32'h6);
    rd(8'h64, 32'h6);
    SELFTEST_FAIL <= 1;
    SELFTEST_DONE <= 1;
    tick(4);
    SELFTEST_DONE <= 0;
    rd(8'h40, 32'h200);
    SELFTEST_FAIL <= 0;
    SELFTEST_DONE <= 1;
    tick(4);
    SELFTEST_DONE <= 0;
    rd(8'h40, 32'h0);
  endtask
  initial begin
    tick(8);
    RESET_N <= 1;
    filters;
    scen_trigger;
    scen_preset;
    scen_ulf;
    scen_power;
    scen_cal;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
